// ===== verilog/stc_pkg.sv
`default_nettype none
package stc_pkg;

	// bus geometry
	localparam int unsigned ADDR_W = 5;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned BE_W = 4;
	localparam int unsigned BYTE_W = 8;

	// register byte addresses, one aligned word each
	localparam logic [ADDR_W-1:0] ADDR_CNT_LO = 5'h00;
	localparam logic [ADDR_W-1:0] ADDR_CNT_HI = 5'h04;
	localparam logic [ADDR_W-1:0] ADDR_CMPA_LO = 5'h08;
	localparam logic [ADDR_W-1:0] ADDR_CMPA_HI = 5'h0c;
	localparam logic [ADDR_W-1:0] ADDR_CTL0 = 5'h10;
	localparam logic [ADDR_W-1:0] ADDR_CTL1 = 5'h14;
	localparam logic [ADDR_W-1:0] ADDR_PERIOD = 5'h18;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h1c;

	// field positions
	localparam int unsigned RUN_BIT = 3;
	localparam int unsigned AF_BIT = 0;
	localparam int unsigned PF_BIT = 1;

	// documented counter shapes
	localparam int unsigned CW_10 = 10;
	localparam int unsigned PW_10 = 3;
	localparam int unsigned CW_16 = 16;
	localparam int unsigned PW_16 = 8;

	// reset values
	localparam logic [BYTE_W-1:0] CTL1_RST = 8'h00;
	localparam logic RUN_RST = 1'b0;
	localparam logic WAIT_RST = 1'b1;

	typedef enum logic [1:0] {
		STC_CMP,
		STC_CAP,
		STC_PWM,
		STC_TMR
	} stc_mode_t;

	// output action codes, compare-match reading
	localparam logic [1:0] ACT_HOLD = 2'h0;
	localparam logic [1:0] ACT_LOW = 2'h1;
	localparam logic [1:0] ACT_HIGH = 2'h2;
	localparam logic [1:0] ACT_TOGGLE = 2'h3;
	// output action codes, pwm reading
	localparam logic [1:0] ACT_INACT = 2'h0;
	localparam logic [1:0] ACT_ACTIVE = 2'h1;
	localparam logic [1:0] ACT_PWM = 2'h2;
	localparam logic [1:0] ACT_PULSE = 2'h3;

	// laid out exactly as control register one, bit 7 first
	typedef struct packed {
		stc_mode_t mode;
		logic [1:0] act;
		logic init_level;
		logic invert;
		logic swap;
		logic clr_sel;
	} stc_ctl1_t;

	typedef struct packed {
		stc_ctl1_t c1;
		logic run;
	} stc_ctrl_t;

	typedef struct packed {
		logic [ADDR_W-1:0] address;
		logic read;
		logic write;
		logic [DATA_W-1:0] writedata;
		logic [BE_W-1:0] byteenable;
	} stc_req_t;

endpackage
`default_nettype wire

// ===== verilog/stc_match.sv
`timescale 1ns/100ps
`default_nettype none
module stc_match #(
	parameter int CW = 10,
	parameter int PW = 3
) (
	input wire logic [CW-1:0] count,
	input wire logic [CW-1:0] cmp_a,
	input wire logic [PW-1:0] pcode,
	input wire logic swap,
	output logic [CW-1:0] count_inc,
	output logic a_match,
	output logic p_match,
	output logic pwm_active
);
	import stc_pkg::*;

	localparam int LW = CW - PW;

	logic [CW:0] p_span;
	logic [CW:0] a_span;
	logic [CW:0] period;
	logic [CW:0] duty;

	// matches look at the value the counter is about to take
	always_comb begin
		count_inc = count + 1'b1;
		a_match = (count_inc == cmp_a);
		// period code meets only the top bits
		p_match = (count_inc[CW-1:LW] == pcode) &&
			(count_inc[LW-1:0] == '0);
		// zero code means a full wrap
		if (pcode == '0) begin
			p_span = {1'b1, {CW{1'b0}}};
		end else begin
			p_span = {1'b0, pcode, {LW{1'b0}}};
		end
		a_span = {1'b0, cmp_a};
		// swap picks period and duty sources
		period = swap ? a_span : p_span;
		duty = swap ? p_span : a_span;
		// duty at or past period pins full duty
		pwm_active = (duty >= period) || ({1'b0, count} < duty);
	end

endmodule
`default_nettype wire

// ===== verilog/stc_pin.sv
`timescale 1ns/100ps
`default_nettype none
module stc_pin (
	input wire logic clock,
	input wire logic rst_n,
	input wire stc_pkg::stc_ctrl_t ctrl,
	input wire logic run_rise,
	input wire logic a_event,
	input wire logic pwm_active,
	output logic pin_out,
	output logic pin_oen
);
	import stc_pkg::*;

	typedef struct packed {
		logic level;
		logic out;
		logic oen;
	} stc_pin_t;

	stc_pin_t s;
	stc_pin_t next_s;

	always_comb begin
		next_s = s;
		next_s.oen = 1'b0;
		case (ctrl.c1.mode)
			STC_CMP: begin
				next_s.oen = 1'b1;
				if (run_rise) begin
					next_s.level = ctrl.c1.init_level;
				end else if (a_event) begin
					// only comparator a moves the pin
					case (ctrl.c1.act)
						ACT_LOW: next_s.level = 1'b0;
						ACT_HIGH: next_s.level = 1'b1;
						ACT_TOGGLE: next_s.level = ~s.level;
						default: next_s.level = s.level;
					endcase
				end
			end
			STC_PWM: begin
				next_s.oen = 1'b1;
				// init level sets the active polarity
				case (ctrl.c1.act)
					ACT_INACT: next_s.level = ~ctrl.c1.init_level;
					ACT_ACTIVE: next_s.level = ctrl.c1.init_level;
					ACT_PWM: next_s.level = pwm_active ?
						ctrl.c1.init_level : ~ctrl.c1.init_level;
					default: next_s.level = ctrl.run ?
						ctrl.c1.init_level : ~ctrl.c1.init_level;
				endcase
			end
			// timer and capture leave the pin to others
			default: next_s.level = s.level;
		endcase
		// undriven modes keep the last pin level, invert included
		if (next_s.oen) begin
			next_s.out = next_s.level ^ ctrl.c1.invert;
		end
		if (!rst_n) begin
			next_s = '0;
		end
	end

	always_ff @(posedge clock) begin
		s <= next_s;
	end

	assign pin_out = s.out;
	assign pin_oen = s.oen;

endmodule
`default_nettype wire

// ===== verilog/stc_timer.sv
// Chosen here: the Avalon-MM register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module stc_timer #(
	parameter int CW = 10,
	parameter int PW = 3
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [stc_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [stc_pkg::DATA_W-1:0] writedata,
	input wire logic [stc_pkg::BE_W-1:0] byteenable,
	output logic [stc_pkg::DATA_W-1:0] readdata,
	output logic waitrequest,
	output logic tm_out,
	output logic tm_out_en
);
	import stc_pkg::*;

	if (!((CW == CW_10 && PW == PW_10) ||
		(CW == CW_16 && PW == PW_16))) begin : g_bad_shape
		$error("stc_timer: unsupported counter shape");
	end

	localparam int HW = CW - BYTE_W;

	typedef struct packed {
		logic [CW-1:0] count;
		logic [CW-1:0] cmp_a;
		logic [PW-1:0] pcode;
		stc_ctrl_t ctl;
		logic run_q;
		logic af;
		logic pf;
		logic waitrequest;
		logic [DATA_W-1:0] readdata;
	} stc_state_t;

	stc_state_t s;
	stc_state_t next_s;
	stc_req_t req;

	logic [CW-1:0] count_inc;
	logic a_match;
	logic p_match;
	logic pwm_active;
	logic run_rise;
	logic tick;
	logic pulse_mode;
	logic clr_by_a;
	logic clear;
	logic set_a;
	logic set_p;
	logic wr_ok;
	logic [DATA_W-1:0] rd_mux;

	assign req = '{address: address, read: read, write: write,
		writedata: writedata, byteenable: byteenable};

	stc_match #(
		.CW(CW),
		.PW(PW)
	) u_match (
		.count(s.count),
		.cmp_a(s.cmp_a),
		.pcode(s.pcode),
		.swap(s.ctl.c1.swap),
		.count_inc(count_inc),
		.a_match(a_match),
		.p_match(p_match),
		.pwm_active(pwm_active)
	);

	stc_pin u_pin (
		.clock(clock),
		.rst_n(rst_n),
		.ctrl(s.ctl),
		.run_rise(run_rise),
		.a_event(tick && a_match),
		.pwm_active(pwm_active),
		.pin_out(tm_out),
		.pin_oen(tm_out_en)
	);

	// event and clearing decisions
	always_comb begin
		run_rise = s.ctl.run & ~s.run_q;
		// first cycle after start only zeroes, so no stale match
		tick = s.ctl.run & s.run_q;
		pulse_mode = (s.ctl.c1.mode == STC_PWM) &&
			(s.ctl.c1.act == ACT_PULSE);
		// mode decides who clears
		case (s.ctl.c1.mode)
			STC_PWM: clr_by_a = s.ctl.c1.swap;
			STC_CAP: clr_by_a = 1'b0;
			// compare and timer share clearing
			default: clr_by_a = s.ctl.c1.clr_sel;
		endcase
		// single pulse never clears; restart does that
		clear = ~pulse_mode && (clr_by_a ? a_match : p_match);
		set_a = tick && a_match && (s.ctl.c1.mode != STC_CAP);
		// no period flag when a clears outside pwm
		set_p = tick && p_match && ~pulse_mode &&
			~(clr_by_a && (s.ctl.c1.mode != STC_PWM));
	end

	// read data multiplexer, narrow fields in the low bits
	always_comb begin
		rd_mux = '0;
		if (req.address == ADDR_CNT_LO) begin
			rd_mux[BYTE_W-1:0] = s.count[BYTE_W-1:0];
		end else if (req.address == ADDR_CNT_HI) begin
			rd_mux[HW-1:0] = s.count[CW-1:BYTE_W];
		end else if (req.address == ADDR_CMPA_LO) begin
			rd_mux[BYTE_W-1:0] = s.cmp_a[BYTE_W-1:0];
		end else if (req.address == ADDR_CMPA_HI) begin
			rd_mux[HW-1:0] = s.cmp_a[CW-1:BYTE_W];
		end else if (req.address == ADDR_CTL0) begin
			rd_mux[RUN_BIT] = s.ctl.run;
		end else if (req.address == ADDR_CTL1) begin
			rd_mux[BYTE_W-1:0] = s.ctl.c1;
		end else if (req.address == ADDR_PERIOD) begin
			rd_mux[PW-1:0] = s.pcode;
		end else if (req.address == ADDR_STATUS) begin
			rd_mux[AF_BIT] = s.af;
			rd_mux[PF_BIT] = s.pf;
		end
	end

	// whole state update
	always_comb begin
		next_s = s;
		next_s.run_q = s.ctl.run;

		// counter: zero on start, count while running, hold when off
		if (run_rise) begin
			next_s.count = '0;
		end else if (tick) begin
			if (clear) begin
				next_s.count = '0;
			end else begin
				next_s.count = count_inc;
			end
		end

		// bus slave: one wait cycle, then answer for one cycle
		next_s.waitrequest = WAIT_RST;
		wr_ok = req.write && ~s.waitrequest && req.byteenable[0];
		if ((req.read || req.write) && s.waitrequest) begin
			next_s.waitrequest = 1'b0;
			if (req.read) begin
				next_s.readdata = rd_mux;
			end
		end

		// register writes; unmapped and read-only words ignore them
		if (wr_ok) begin
			if (req.address == ADDR_CMPA_LO) begin
				next_s.cmp_a[BYTE_W-1:0] = req.writedata[BYTE_W-1:0];
			end else if (req.address == ADDR_CMPA_HI) begin
				next_s.cmp_a[CW-1:BYTE_W] = req.writedata[HW-1:0];
			end else if (req.address == ADDR_CTL0) begin
				next_s.ctl.run = req.writedata[RUN_BIT];
			end else if (req.address == ADDR_CTL1) begin
				next_s.ctl.c1 = stc_ctl1_t'(req.writedata[BYTE_W-1:0]);
			end else if (req.address == ADDR_PERIOD) begin
				next_s.pcode = req.writedata[PW-1:0];
			end
		end

		// sticky flags, a set in the clear cycle wins
		next_s.af = set_a |
			(s.af & ~(wr_ok && (req.address == ADDR_STATUS) &&
			req.writedata[AF_BIT]));
		next_s.pf = set_p |
			(s.pf & ~(wr_ok && (req.address == ADDR_STATUS) &&
			req.writedata[PF_BIT]));

		// single pulse ends itself on an a match
		if (pulse_mode && tick && a_match) begin
			next_s.ctl.run = 1'b0;
		end

		if (!rst_n) begin
			next_s = '0;
			next_s.ctl.c1 = stc_ctl1_t'(CTL1_RST);
			next_s.ctl.run = RUN_RST;
			next_s.waitrequest = WAIT_RST;
		end
	end

	always_ff @(posedge clock) begin
		s <= next_s;
	end

	assign readdata = s.readdata;
	assign waitrequest = s.waitrequest;

endmodule
`default_nettype wire

// ===== dv/stc_timer_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module stc_timer_assertions
	import stc_pkg::*;
	#(parameter int CW = 10, parameter int PW = 3) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [stc_pkg::ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [stc_pkg::DATA_W-1:0] writedata,
	input wire logic [stc_pkg::BE_W-1:0] byteenable,
	input wire logic [stc_pkg::DATA_W-1:0] readdata,
	input wire logic waitrequest,
	input wire logic tm_out,
	input wire logic tm_out_en
);
	// shadow of control one; age lets the registered pin path settle
	stc_ctl1_t c1;
	logic [1:0] age;
	logic ans;
	logic pin_on;
	logic lvl;
	assign ans = read && !waitrequest;
	assign pin_on = (c1.mode == STC_CMP) || (c1.mode == STC_PWM);
	assign lvl = c1.init_level ^ c1.invert;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			c1 <= '0;
			age <= 2'h0;
		end else if (write && !waitrequest && byteenable[0] &&
			address == ADDR_CTL1) begin
			c1 <= stc_ctl1_t'(writedata[BYTE_W-1:0]);
			age <= 2'h0;
		end else if (age != 2'h3) begin
			age <= age + 2'h1;
		end
	end
	sequence s_answer;
		!waitrequest ##1 waitrequest;
	endsequence
	a_wait_pulse: assert property (
		(read || write) && waitrequest |=> s_answer)
		else $error("bus answer not a single cycle");
	a_cnt_hi_bits: assert property (
		ans && address == ADDR_CNT_HI |->
		readdata[DATA_W-1:CW-BYTE_W] == '0)
		else $error("counter high upper bits not zero");
	a_cmpa_hi_bits: assert property (
		ans && address == ADDR_CMPA_HI |->
		readdata[DATA_W-1:CW-BYTE_W] == '0)
		else $error("compare high upper bits not zero");
	a_status_bits: assert property (
		ans && address == ADDR_STATUS |-> readdata[DATA_W-1:PF_BIT+1] == '0)
		else $error("status upper bits not zero");
	a_pin_enable: assert property (
		age == 2'h3 |-> tm_out_en == pin_on)
		else $error("pin enable does not follow mode");
	a_pin_hold_off: assert property (
		!tm_out_en && $past(!tm_out_en) |-> $stable(tm_out))
		else $error("pin moved while not driven");
	a_force_active: assert property (
		age == 2'h3 && c1.mode == STC_PWM && c1.act == ACT_ACTIVE |->
		tm_out == lvl)
		else $error("forced active level wrong");
	a_force_inact: assert property (
		age == 2'h3 && c1.mode == STC_PWM && c1.act == ACT_INACT |->
		tm_out != lvl)
		else $error("forced inactive level wrong");
endmodule
bind stc_timer stc_timer_assertions #(
	.CW(CW),
	.PW(PW)
) i_stc_timer_assertions (
	.clock(clock),
	.rst_n(rst_n),
	.address(address),
	.read(read),
	.write(write),
	.writedata(writedata),
	.byteenable(byteenable),
	.readdata(readdata),
	.waitrequest(waitrequest),
	.tm_out(tm_out),
	.tm_out_en(tm_out_en)
);
`default_nettype wire

// ===== dv/stc_timer_bench.sv
`timescale 1ns/100ps
`default_nettype none
module stc_timer_bench;
	import stc_pkg::*;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [ADDR_W-1:0] address = '0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [DATA_W-1:0] writedata = '0;
	logic [BE_W-1:0] byteenable = '0;
	logic [DATA_W-1:0] readdata;
	logic waitrequest;
	logic tm_out;
	logic tm_out_en;
	logic [DATA_W-1:0] q;
	int err_total = 0;
	int n_tests = 0;
	int cyc = 0;
	int hi;
	// ctl1, compare a, period code, window, expected high samples
	logic [47:0] tbl [12] = '{48'ha8_040_2_100_040, 48'ha8_300_2_100_100,
		48'hac_040_2_100_0c0, 48'haa_12c_1_12c_080, 48'ha8_064_0_400_064,
		48'h98_040_2_100_100, 48'h88_040_2_100_000, 48'h08_040_2_100_100,
		48'h31_064_2_0c8_064, 48'h21_064_2_0c8_0c8, 48'h19_064_2_0c8_000,
		48'hb8_040_2_100_000};
	always #25 clock = ~clock;
	stc_timer #(.CW(10), .PW(3)) i_stc_timer (.clock(clock), .rst_n(rst_n),
		.address(address), .read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .tm_out(tm_out), .tm_out_en(tm_out_en));
	task end_of_test;
		if (err_total == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	// request held until waitrequest is seen low at an edge
	task bus(input logic [ADDR_W-1:0] a, input logic w, input logic [31:0] d,
		input logic [3:0] be);
		@(posedge clock);
		address <= a;
		read <= !w;
		write <= w;
		writedata <= d;
		byteenable <= be;
		// no local limit: only the bench timeout ends a wait
		do begin
			@(posedge clock);
		end while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		bus(a, 1'b1, {24'h0, d}, 4'hf);
	endtask
	task rc(input logic [ADDR_W-1:0] a, input string nm, input logic [31:0] e);
		bus(a, 1'b0, 32'h0, 4'hf);
		chk(nm, q, e);
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc > 40000) begin
			err_total++;
			end_of_test();
		end
	end
	initial begin
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		rc(ADDR_CNT_LO, "count low", 32'h0);
		rc(ADDR_CNT_HI, "count high", 32'h0);
		rc(ADDR_CMPA_LO, "cmpa low", 32'h0);
		rc(ADDR_CMPA_HI, "cmpa high", 32'h0);
		wr(ADDR_CMPA_LO, 8'hff);
		wr(ADDR_CMPA_HI, 8'hff);
		bus(ADDR_CMPA_LO, 1'b1, 32'h12, 4'he);
		wr(ADDR_CNT_LO, 8'h55);
		rc(ADDR_CMPA_LO, "cmpa low", 32'hff);
		rc(ADDR_CMPA_HI, "cmpa high", 32'h3);
		rc(ADDR_CNT_LO, "count ro", 32'h0);
		rc(5'h02, "unmapped", 32'h0);
		// compare a nonzero: zero is not allowed in compare mode
		wr(ADDR_CMPA_HI, 8'h0);
		wr(ADDR_CMPA_LO, 8'h40);
		wr(ADDR_PERIOD, 8'h1);
		wr(ADDR_CTL1, 8'h00);
		wr(ADDR_CTL0, 8'h08);
		repeat (300) @(posedge clock);
		wr(ADDR_CTL0, 8'h00);
		rc(ADDR_CNT_HI, "p clear high", 32'h0);
		// stop lands 303 edges after start: 302 mod 128 counts
		rc(ADDR_CNT_LO, "held count", 32'h2e);
		rc(ADDR_CNT_LO, "still held", 32'h2e);
		rc(ADDR_STATUS, "both flags", 32'h3);
		wr(ADDR_STATUS, 8'h3);
		rc(ADDR_STATUS, "flags cleared", 32'h0);
		wr(ADDR_CMPA_HI, 8'h1);
		wr(ADDR_CMPA_LO, 8'h0);
		wr(ADDR_CTL1, 8'h01);
		wr(ADDR_CTL0, 8'h08);
		repeat (600) @(posedge clock);
		wr(ADDR_CTL0, 8'h00);
		rc(ADDR_CNT_HI, "a clear high", 32'h0);
		rc(ADDR_STATUS, "a flag only", 32'h1);
		wr(ADDR_CTL1, 8'hc0);
		repeat (4) @(posedge clock);
		chk("pin enable", {31'h0, tm_out_en}, 32'h0);
		wr(ADDR_CTL1, 8'hc4);
		repeat (4) @(posedge clock);
		chk("pin held", {31'h0, tm_out}, 32'h0);
		for (int i = 0; i < 12; i++) begin
			wr(ADDR_CTL0, 8'h00);
			wr(ADDR_CTL1, tbl[i][47:40]);
			wr(ADDR_CMPA_LO, tbl[i][35:28]);
			wr(ADDR_CMPA_HI, {6'h0, tbl[i][37:36]});
			wr(ADDR_PERIOD, {4'h0, tbl[i][27:24]});
			wr(ADDR_CTL0, 8'h08);
			// settle past one full period, then count one window
			repeat (1100) @(posedge clock);
			hi = 0;
			repeat (tbl[i][23:12]) begin
				@(posedge clock);
				if (tm_out === 1'b1)
					hi++;
			end
			chk("pin high count", hi, {20'h0, tbl[i][11:0]});
		end
		// last entry is a single pulse: a match at 64 stops the run
		rc(ADDR_CTL0, "pulse run", 32'h0);
		rc(ADDR_CNT_LO, "pulse stop", 32'h40);
		end_of_test();
	end
endmodule
`default_nettype wire
